//--- shared/aps_regs.vh
// Register map, field positions, reset values and timing counts
`ifndef APS_REGS_VH
`define APS_REGS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define APS_OFF_CTL0 8'h00
`define APS_OFF_CTL1 8'h04
`define APS_OFF_RESH 8'h08
`define APS_OFF_RESL 8'h0c
`define APS_OFF_FLAG 8'h10
`define APS_OFF_MAP 8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define APS_CTL0_ON 0
`define APS_CTL0_GO 2
`define APS_CTL0_CHS 5:3
`define APS_CTL0_CKS 7:6
`define APS_CTL1_FMT 7
`define APS_CTL1_CFG 3:0
`define APS_FLAG_DONE 0
`define APS_FLAG_IE 1
`define APS_MAP_MASK 7:0
`define APS_MAP_VPOS 8
`define APS_MAP_VNEG 9

// ---------------------------------------------------------------
// Reset values and small-package pin mask
// ---------------------------------------------------------------
`define APS_RST_BYTE 8'h00
`define APS_RST_CFG 4'h0
`define APS_SMALL_MASK 8'h1f

// ---------------------------------------------------------------
// Timing: clocks per bit period (minus one) and period counts
// ---------------------------------------------------------------
`define APS_DIV_2 6'h01
`define APS_DIV_8 6'h07
`define APS_DIV_32 6'h1f
`define APS_DIV_64 6'h3f
`define APS_CONV_LAST 4'hb
`define APS_WAIT_LAST 4'h1

`endif

//--- logic/aps_sar.v
// Successive-approximation sequencer with bit-period prescaler
`include "aps_regs.vh"

module aps_sar (
    input wire i_clk,
    input wire i_rst,
    input wire i_start,
    input wire i_abort,
    input wire [1:0] i_div_sel,
    input wire i_cmp,
    output wire o_busy,
    output wire o_idle,
    output wire o_sample,
    output reg o_done,
    output reg [9:0] o_result,
    output wire [9:0] o_dac
);

    // ---------------------------------------------------------------
    // State codes
    // ---------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_CONV = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;

    reg [1:0] state_r;  // Sequencer state
    reg [5:0] pre_r;    // Clock count inside one bit period
    reg [3:0] per_r;    // Bit period index
    reg [9:0] sar_r;    // Trial code driven to the DAC
    reg [5:0] div_max;  // Last prescaler count for chosen clock
    wire tick;          // Last clock of a bit period
    wire [9:0] sar_nxt; // Trial code after this period

    assign tick = (pre_r == div_max);
    assign o_busy = (state_r == ST_CONV);
    assign o_idle = (state_r == ST_IDLE);
    assign o_sample = (state_r == ST_IDLE);  // Hold cap tracks input
    assign o_dac = sar_r;

    // Bit period length from the clock select field
    always @* begin
        case (i_div_sel)
            2'h0: div_max = `APS_DIV_2;
            2'h1: div_max = `APS_DIV_8;
            2'h2: div_max = `APS_DIV_32;
            default: div_max = `APS_DIV_64;
        endcase
    end

    // ---------------------------------------------------------------
    // Per-bit trial: set the next bit, decide the bit under test
    // ---------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < 10; b = b + 1) begin : g_bit
            localparam integer SET_I = 9 - b;    // Period that sets the bit
            localparam integer DEC_I = 10 - b;   // Period that decides it
            localparam [3:0] P_SET = SET_I[3:0];
            localparam [3:0] P_DEC = DEC_I[3:0];
            // Comparator high keeps the bit, low drops it
            assign sar_nxt[b] = (per_r == P_SET) ? 1'b1 :
                                (per_r == P_DEC) ? (sar_r[b] & i_cmp) :
                                sar_r[b];
        end
    endgenerate

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        if (i_rst) begin
            state_r <= ST_IDLE;
            pre_r <= 6'h00;
            per_r <= 4'h0;
            sar_r <= 10'h000;
            o_result <= 10'h000;
        end else begin
            case (state_r)
                // Acquiring: wait for a start request
                ST_IDLE: begin
                    if (i_start) begin
                        state_r <= ST_CONV;
                        pre_r <= 6'h00;
                        per_r <= 4'h0;
                        sar_r <= 10'h000;
                    end
                end
                // Converting: twelve bit periods in all
                ST_CONV: begin
                    if (i_abort) begin
                        state_r <= ST_WAIT;
                        pre_r <= 6'h00;
                        per_r <= 4'h0;
                    end else if (tick) begin
                        pre_r <= 6'h00;
                        if (per_r == `APS_CONV_LAST) begin
                            o_result <= sar_r;
                            o_done <= 1'b1;
                            state_r <= ST_WAIT;
                            per_r <= 4'h0;
                        end else begin
                            per_r <= per_r + 4'h1;
                            sar_r <= sar_nxt;
                        end
                    end else begin
                        pre_r <= pre_r + 6'h01;
                    end
                end
                // Two bit periods with the hold cap disconnected
                ST_WAIT: begin
                    if (tick) begin
                        pre_r <= 6'h00;
                        if (per_r == `APS_WAIT_LAST) begin
                            state_r <= ST_IDLE;
                        end else begin
                            per_r <= per_r + 4'h1;
                        end
                    end else begin
                        pre_r <= pre_r + 6'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

//--- logic/aps_top.v
// Converter control: APB registers, pin map decode, conversion control
//
// What this block does
// - Load 10-bit result into result pair on completion
// - Clear start/busy bit when conversion finishes
// - Set completion flag with the result load
// - Codes 0010, 0011, 011x pin maps
// - Codes 0100, 0101, 1000 pin maps
// - Codes 1001, 1010, 1011 pin maps
// - Code 1100 map; small package lacks 5-7
// - Writing one to start/busy requests conversion
// - Two bit periods before next acquisition
// - Justify result by format bit, zero fill
// - Clearing start/busy aborts, result kept
// - Conversion lasts twelve bit periods
//
// The implementer's own choices: the register offsets and the APB register port.
`include "aps_regs.vh"

module aps_top #(
    parameter SMALL_PKG = 0
) (
    input wire I_CLK,
    input wire I_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output wire [31:0] O_PRDATA,
    output wire O_PREADY,
    output wire O_PSLVERR,
    input wire I_CMP,
    output wire [9:0] O_DAC_CODE,
    output wire O_SAMPLE,
    output wire [2:0] O_CHANNEL,
    output wire O_ENABLED,
    output wire [7:0] O_ANALOG_MASK,
    output wire O_VREF_POS_EXT,
    output wire O_VREF_NEG_EXT,
    output wire O_COMPLETE_FLAG,
    output wire O_IRQ_ENABLE
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg on_r;            // Converter switched on
    reg [2:0] chs_r;     // Selected input channel
    reg [1:0] cks_r;     // Conversion clock select
    reg fmt_r;           // Result format select, 1 = right
    reg [3:0] cfg_r;     // Port configuration code
    reg [7:0] resh_r;    // Result high byte
    reg [7:0] resl_r;    // Result low byte
    reg flag_r;          // Conversion complete flag
    reg ie_r;            // Conversion interrupt enable
    reg [31:0] prdata_r; // Read data captured in setup phase
    reg [7:0] mask_r;    // Analog pin mask
    reg vpos_r;          // Positive reference from pin 3
    reg vneg_r;          // Negative reference from pin 2
    reg cmp_s1_r;        // Comparator synchroniser, first stage
    reg cmp_s2_r;        // Comparator synchroniser, second stage

    reg [7:0] dec_mask;  // Decoded analog mask
    reg dec_vpos;        // Decoded positive reference
    reg dec_vneg;        // Decoded negative reference
    reg [31:0] rd_val;   // Read mux
    reg hit;             // Address is mapped

    wire busy;
    wire idle;
    wire done;
    wire [9:0] result;
    wire acc;
    wire wr;
    wire wr_ctl0;
    wire start;
    wire abort;

    // ---------------------------------------------------------------
    // APB handshake: one access cycle, no extra wait states
    // ---------------------------------------------------------------
    assign acc = I_PSEL & I_PENABLE;
    assign O_PREADY = acc;
    assign O_PSLVERR = acc & ~hit;
    assign O_PRDATA = prdata_r;
    assign wr = acc & I_PWRITE & hit;
    assign wr_ctl0 = wr & (I_PADDR == `APS_OFF_CTL0);

    // Start only from idle, with on already set and kept set
    assign start = wr_ctl0 & idle & on_r & I_PWDATA[`APS_CTL0_ON] &
                   I_PWDATA[`APS_CTL0_GO];
    // Dropping start/busy or switching off mid-conversion aborts
    assign abort = wr_ctl0 & busy &
                   ~(I_PWDATA[`APS_CTL0_GO] &
                     I_PWDATA[`APS_CTL0_ON]);

    // Address decode and read mux
    always @* begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (I_PADDR)
            `APS_OFF_CTL0: begin
                rd_val[`APS_CTL0_CKS] = cks_r;
                rd_val[`APS_CTL0_CHS] = chs_r;
                rd_val[`APS_CTL0_GO] = busy;
                rd_val[`APS_CTL0_ON] = on_r;
            end
            `APS_OFF_CTL1: begin
                rd_val[`APS_CTL1_FMT] = fmt_r;
                rd_val[`APS_CTL1_CFG] = cfg_r;
            end
            `APS_OFF_RESH: rd_val[7:0] = resh_r;
            `APS_OFF_RESL: rd_val[7:0] = resl_r;
            `APS_OFF_FLAG: begin
                rd_val[`APS_FLAG_DONE] = flag_r;
                rd_val[`APS_FLAG_IE] = ie_r;
            end
            `APS_OFF_MAP: begin
                rd_val[`APS_MAP_MASK] = mask_r;
                rd_val[`APS_MAP_VPOS] = vpos_r;
                rd_val[`APS_MAP_VNEG] = vneg_r;
            end
            default: hit = 1'b0;
        endcase
    end

    // Read data latched in the setup cycle
    always @(posedge I_CLK) begin
        if (I_RST) begin
            prdata_r <= 32'h0000_0000;
        end else if (I_PSEL & ~I_PENABLE) begin
            prdata_r <= rd_val;
        end
    end

    // ---------------------------------------------------------------
    // Software registers
    // ---------------------------------------------------------------
    always @(posedge I_CLK) begin
        if (I_RST) begin
            on_r <= 1'b0;
            chs_r <= 3'h0;
            cks_r <= 2'h0;
            fmt_r <= 1'b0;
            cfg_r <= `APS_RST_CFG;
            ie_r <= 1'b0;
        end else if (wr) begin
            if (I_PADDR == `APS_OFF_CTL0) begin
                on_r <= I_PWDATA[`APS_CTL0_ON];
                chs_r <= I_PWDATA[`APS_CTL0_CHS];
                cks_r <= I_PWDATA[`APS_CTL0_CKS];
            end
            if (I_PADDR == `APS_OFF_CTL1) begin
                fmt_r <= I_PWDATA[`APS_CTL1_FMT];
                cfg_r <= I_PWDATA[`APS_CTL1_CFG];
            end
            if (I_PADDR == `APS_OFF_FLAG) begin
                ie_r <= I_PWDATA[`APS_FLAG_IE];
            end
        end
    end

    // Result pair: completion wins over a software write
    always @(posedge I_CLK) begin
        if (I_RST) begin
            resh_r <= `APS_RST_BYTE;
            resl_r <= `APS_RST_BYTE;
        end else if (done) begin
            if (fmt_r) begin
                resh_r <= {6'h00, result[9:8]};
                resl_r <= result[7:0];
            end else begin
                resh_r <= result[9:2];
                resl_r <= {result[1:0], 6'h00};
            end
        end else if (wr) begin
            if (I_PADDR == `APS_OFF_RESH) begin
                resh_r <= I_PWDATA[7:0];
            end
            if (I_PADDR == `APS_OFF_RESL) begin
                resl_r <= I_PWDATA[7:0];
            end
        end
    end

    // Completion flag: set wins over the software clear
    always @(posedge I_CLK) begin
        if (I_RST) begin
            flag_r <= 1'b0;
        end else if (done) begin
            flag_r <= 1'b1;
        end else if (wr & (I_PADDR == `APS_OFF_FLAG)) begin
            flag_r <= I_PWDATA[`APS_FLAG_DONE];
        end
    end

    // ---------------------------------------------------------------
    // Pin map decode
    // ---------------------------------------------------------------
    always @* begin
        dec_vpos = 1'b0;
        dec_vneg = 1'b0;
        case (cfg_r)
            4'h0: dec_mask = 8'hff;
            4'h1: begin
                dec_mask = 8'hf7;
                dec_vpos = 1'b1;
            end
            4'h2: dec_mask = 8'h1f;
            4'h3: begin
                dec_mask = 8'h17;
                dec_vpos = 1'b1;
            end
            4'h4: dec_mask = 8'h0b;
            4'h5: begin
                dec_mask = 8'h03;
                dec_vpos = 1'b1;
            end
            4'h6, 4'h7: dec_mask = 8'h00;
            4'h8: begin
                dec_mask = 8'hf3;
                dec_vpos = 1'b1;
                dec_vneg = 1'b1;
            end
            4'h9: dec_mask = 8'h3f;
            4'ha: begin
                dec_mask = 8'h37;
                dec_vpos = 1'b1;
            end
            4'hb: begin
                dec_mask = 8'h33;
                dec_vpos = 1'b1;
                dec_vneg = 1'b1;
            end
            4'hc: begin
                dec_mask = 8'h13;
                dec_vpos = 1'b1;
                dec_vneg = 1'b1;
            end
            // Remaining codes: all pins digital
            default: dec_mask = 8'h00;
        endcase
    end

    // Registered map; pins 5-7 absent on the small package
    always @(posedge I_CLK) begin
        if (I_RST) begin
            mask_r <= 8'h00;
            vpos_r <= 1'b0;
            vneg_r <= 1'b0;
        end else begin
            mask_r <= (SMALL_PKG != 0) ? (dec_mask & `APS_SMALL_MASK)
                                       : dec_mask;
            vpos_r <= dec_vpos;
            vneg_r <= dec_vneg;
        end
    end

    // Comparator pin synchroniser
    always @(posedge I_CLK) begin
        if (I_RST) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end else begin
            cmp_s1_r <= I_CMP;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    aps_sar u_sar (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_start(start),
        .i_abort(abort),
        .i_div_sel(cks_r),
        .i_cmp(cmp_s2_r),
        .o_busy(busy),
        .o_idle(idle),
        .o_sample(O_SAMPLE),
        .o_done(done),
        .o_result(result),
        .o_dac(O_DAC_CODE)
    );

    assign O_CHANNEL = chs_r;
    assign O_ENABLED = on_r;
    assign O_ANALOG_MASK = mask_r;
    assign O_VREF_POS_EXT = vpos_r;
    assign O_VREF_NEG_EXT = vneg_r;
    assign O_COMPLETE_FLAG = flag_r;
    assign O_IRQ_ENABLE = ie_r;

endmodule

//--- verification/aps_checker.sv
// Concurrent checks on the converter control ports
module aps_checker #(
    parameter SMALL_PKG = 0
) (
    input wire I_CLK,
    input wire I_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [7:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire [31:0] O_PRDATA,
    input wire O_PREADY,
    input wire O_PSLVERR,
    input wire I_CMP,
    input wire [9:0] O_DAC_CODE,
    input wire O_SAMPLE,
    input wire [2:0] O_CHANNEL,
    input wire O_ENABLED,
    input wire [7:0] O_ANALOG_MASK,
    input wire O_VREF_POS_EXT,
    input wire O_VREF_NEG_EXT,
    input wire O_COMPLETE_FLAG,
    input wire O_IRQ_ENABLE
);
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------------------------
    // Helper logic
    // -----------------------------------------------------------
    // Expected {neg ref, pos ref, analog mask} for each config code
    localparam logic [9:0] MAP [16] = '{10'h0ff, 10'h1f7, 10'h01f,
        10'h117, 10'h00b, 10'h103, 10'h000, 10'h000, 10'h3f3, 10'h03f,
        10'h137, 10'h333, 10'h313, 10'h000, 10'h000, 10'h000};
    // Small package has no pins 5 to 7
    wire [9:0] pkg_keep = (SMALL_PKG != 0) ? 10'h31f : 10'h3ff;
    wire acc_wr = I_PSEL && I_PENABLE && I_PWRITE;
    wire wr_ctl0 = acc_wr && (I_PADDR == 8'h00);
    wire wr_ctl1 = acc_wr && (I_PADDR == 8'h04);
    wire wr_flag = acc_wr && (I_PADDR == 8'h10);
    wire [9:0] map_now = {O_VREF_NEG_EXT, O_VREF_POS_EXT, O_ANALOG_MASK};
    logic sw_set_r; // Software set the flag at the last edge
    logic [7:0] low_run_r; // Cycles in a row with the hold cap cut off
    // Track software flag sets and the length of the sampling gap
    always @(posedge I_CLK) begin
        if (I_RST) begin
            sw_set_r <= 1'b0;
            low_run_r <= 8'h00;
        end else begin
            sw_set_r <= wr_flag && I_PWDATA[0];
            if (O_SAMPLE)
                low_run_r <= 8'h00;
            else if (low_run_r != 8'hff)
                low_run_r <= low_run_r + 8'h01;
        end
    end
    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // Flag raised by the converter, not by software
    sequence s_done;
        $rose(O_COMPLETE_FLAG) && !sw_set_r;
    endsequence
    // Settling gap, then acquisition resumes
    sequence s_rest;
        (!O_SAMPLE) [*3] ##[1:200] O_SAMPLE;
    endsequence
    property p_map(logic sel);
        wr_ctl1 && sel |-> ##2
            (map_now == (MAP[$past(I_PWDATA[3:0], 2)] & pkg_keep));
    endproperty
    chk_map_low_codes: assert property (
        p_map(I_PWDATA[3:0] inside {4'h2, 4'h3, 4'h6, 4'h7}))
        else $error("pin map wrong for codes 2 3 6 7");
    chk_map_mid_codes: assert property (
        p_map(I_PWDATA[3:0] inside {4'h4, 4'h5, 4'h8}))
        else $error("pin map wrong for codes 4 5 8");
    chk_map_wide_codes: assert property (
        p_map(I_PWDATA[3:0] inside {4'h9, 4'ha, 4'hb}))
        else $error("pin map wrong for codes 9 a b");
    chk_map_top_code: assert property (
        p_map(I_PWDATA[3:0] == 4'hc))
        else $error("pin map wrong for code c");
    chk_start_taken: assert property (
        wr_ctl0 && I_PWDATA[0] && I_PWDATA[2] && O_ENABLED && O_SAMPLE
        |-> ##[1:70] !O_SAMPLE) else $error("start not taken");
    chk_start_off_ignored: assert property (
        wr_ctl0 && I_PWDATA[2] && !O_ENABLED && O_SAMPLE
        |=> O_SAMPLE [*3]) else $error("start taken while off");
    chk_done_in_conv: assert property (s_done |-> !O_SAMPLE)
        else $error("flag raised outside a conversion");
    chk_conv_length: assert property (s_done |-> low_run_r >= 8'd24)
        else $error("conversion shorter than twelve periods");
    chk_wait_after: assert property (s_done |=> s_rest)
        else $error("settling gap after conversion wrong");
    chk_flag_holds: assert property (
        O_COMPLETE_FLAG && !wr_flag |=> O_COMPLETE_FLAG)
        else $error("flag dropped without a write");
    chk_abort_no_flag: assert property (
        wr_ctl0 && !(I_PWDATA[0] && I_PWDATA[2]) && !O_SAMPLE
        && !O_COMPLETE_FLAG |=> (!O_COMPLETE_FLAG) [*8])
        else $error("flag raised after abort");
endmodule

//--- verification/test_aps_top.sv
// Register-level testbench for the converter control block
module test_aps_top;
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------------------------
    // Signals and design
    // -----------------------------------------------------------
    localparam logic [9:0] MAP [16] = '{10'h0ff, 10'h1f7, 10'h01f,
        10'h117, 10'h00b, 10'h103, 10'h000, 10'h000, 10'h3f3, 10'h03f,
        10'h137, 10'h333, 10'h313, 10'h000, 10'h000, 10'h000};
    logic I_CLK = 1'b0, I_RST = 1'b1, I_PSEL = 1'b0, I_PENABLE = 1'b0;
    logic I_PWRITE = 1'b0, I_CMP = 1'b0;
    logic [7:0] I_PADDR = 8'h00;
    logic [31:0] I_PWDATA = 32'h0;
    wire [31:0] O_PRDATA;
    wire O_PREADY, O_PSLVERR, O_SAMPLE, O_ENABLED, O_VREF_POS_EXT;
    wire O_VREF_NEG_EXT, O_COMPLETE_FLAG, O_IRQ_ENABLE;
    wire [9:0] O_DAC_CODE;
    wire [2:0] O_CHANNEL;
    wire [7:0] O_ANALOG_MASK;
    logic [31:0] rd_v; // Read data of the last transfer
    logic err_v; // Error response of the last transfer
    logic [9:0] target = 10'h000; // Analog input level being converted
    int n_fail = 0, n_checks = 0, cyc = 0, t0;
    aps_top #(.SMALL_PKG(0)) dut (.I_CLK(I_CLK), .I_RST(I_RST),
        .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
        .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
        .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_CMP(I_CMP),
        .O_DAC_CODE(O_DAC_CODE), .O_SAMPLE(O_SAMPLE),
        .O_CHANNEL(O_CHANNEL), .O_ENABLED(O_ENABLED),
        .O_ANALOG_MASK(O_ANALOG_MASK), .O_VREF_POS_EXT(O_VREF_POS_EXT),
        .O_VREF_NEG_EXT(O_VREF_NEG_EXT),
        .O_COMPLETE_FLAG(O_COMPLETE_FLAG), .O_IRQ_ENABLE(O_IRQ_ENABLE));
    always #20 I_CLK = ~I_CLK;
    // Comparator: input at or above the trial code reads high
    always @(posedge I_CLK) begin
        I_CMP <= (target >= O_DAC_CODE);
        cyc <= cyc + 1;
    end
    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    // One APB transfer, held until ready is seen at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_PSEL <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE <= wr;
        I_PADDR <= a;
        I_PWDATA <= d;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        @(posedge I_CLK);
        while (O_PREADY !== 1'b1)
            @(posedge I_CLK);
        rd_v = O_PRDATA;
        err_v = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask
    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict;
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Start one conversion and poll until the busy bit drops
    task convert(input logic [9:0] lvl);
        int k;
        target = lvl;
        repeat (20) @(posedge I_CLK); // Acquisition time
        apb(1'b1, 8'h00, 32'h5d);
        t0 = cyc;
        apb(1'b0, 8'h00, 32'h0);
        check("busy after start", rd_v, 32'h5d);
        k = 0;
        while (rd_v[2] !== 1'b0 && k < 300) begin
            apb(1'b0, 8'h00, 32'h0);
            k++;
        end
        check("conversion time", cyc - t0 >= 96, 1);
        #1 check("gap after done", O_SAMPLE, 0);
        check("busy cleared", rd_v, 32'h59);
        check("dac holds result", O_DAC_CODE, lvl);
        apb(1'b1, 8'h00, 32'h5d);
        apb(1'b0, 8'h00, 32'h0);
        check("start in gap", rd_v, 32'h59);
        apb(1'b0, 8'h10, 32'h0);
        check("complete flag", rd_v, 32'h3);
        repeat (40) @(posedge I_CLK);
    endtask
    // -----------------------------------------------------------
    // Tests
    // -----------------------------------------------------------
    initial begin
        repeat (2) @(posedge I_CLK);
        I_RST <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        check("ctl0 reset", rd_v, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check("flag reset", rd_v, 32'h0);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 8'h04, i);
            apb(1'b0, 8'h14, 32'h0);
            check("pin map", rd_v, {22'h0, MAP[i]});
        end
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped error", err_v, 1);
        check("unmapped data", rd_v, 32'h0);
        apb(1'b1, 8'h00, 32'h44);
        apb(1'b0, 8'h00, 32'h0);
        check("start while off", rd_v, 32'h40);
        apb(1'b1, 8'h04, 32'h82); // Pins, format, then channel and on
        apb(1'b1, 8'h00, 32'h5d);
        apb(1'b0, 8'h00, 32'h0);
        check("start with turn on", rd_v, 32'h59);
        check("channel", O_CHANNEL, 3);
        check("enabled", O_ENABLED, 1);
        apb(1'b1, 8'h10, 32'h2); // Clear flag, enable interrupt
        #1 check("irq enable", O_IRQ_ENABLE, 1);
        convert(10'h2a5);
        apb(1'b0, 8'h08, 32'h0);
        check("right high", rd_v, 32'h02);
        apb(1'b0, 8'h0c, 32'h0);
        check("right low", rd_v, 32'ha5);
        apb(1'b0, 8'h10, 32'h0);
        check("flag kept on read", rd_v, 32'h3);
        apb(1'b1, 8'h10, 32'h2);
        apb(1'b1, 8'h04, 32'h02);
        convert(10'h2a5);
        apb(1'b0, 8'h08, 32'h0);
        check("left high", rd_v, 32'ha9);
        apb(1'b0, 8'h0c, 32'h0);
        check("left low", rd_v, 32'h40);
        apb(1'b1, 8'h10, 32'h2);
        apb(1'b0, 8'h10, 32'h0);
        check("flag cleared", rd_v, 32'h2);
        target = 10'h055;
        apb(1'b1, 8'h00, 32'h5d);
        repeat (30) @(posedge I_CLK);
        apb(1'b1, 8'h00, 32'h59);
        repeat (150) @(posedge I_CLK);
        apb(1'b0, 8'h10, 32'h0);
        check("flag after abort", rd_v, 32'h2);
        apb(1'b0, 8'h08, 32'h0);
        check("result after abort", rd_v, 32'ha9);
        apb(1'b0, 8'h00, 32'h0);
        check("busy after abort", rd_v, 32'h59);
        print_verdict;
    end
    // Watchdog against a hung wait
    initial begin
        repeat (20000) @(posedge I_CLK);
        n_fail++;
        print_verdict;
    end
endmodule

bind aps_top aps_checker #(.SMALL_PKG(SMALL_PKG)) u_chk (.I_CLK(I_CLK),
    .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_CMP(I_CMP), .O_DAC_CODE(O_DAC_CODE), .O_SAMPLE(O_SAMPLE),
    .O_CHANNEL(O_CHANNEL), .O_ENABLED(O_ENABLED),
    .O_ANALOG_MASK(O_ANALOG_MASK), .O_VREF_POS_EXT(O_VREF_POS_EXT),
    .O_VREF_NEG_EXT(O_VREF_NEG_EXT), .O_COMPLETE_FLAG(O_COMPLETE_FLAG),
    .O_IRQ_ENABLE(O_IRQ_ENABLE));
